// [host_spi_model.sv]
/*
 * Host controller model for the serial configuration port: frames of a
 * 16-bit instruction and one or two data bytes.
 * Assumes the device drives sdio_out/sdo_out with output enables; the
 * model resolves the two-way data line and feeds it back to sdio_in.
 */
`timescale 1ns/1ps

module host_spi_model (
   // Pins driven by the host
   output logic sclk,
   output logic cs_n,
   output logic sdio_in,
   // Pins driven by the device
   input wire logic sdio_out,
   input wire logic sdio_oe,
   input wire logic sdo_out,
   input wire logic sdo_oe
);
   localparam realtime HALF = 62.5;
   logic h_d;
   logic h_oe;
   logic saw_sdio;
   logic saw_sdo;

   // ==========================================
   // Line resolution
   // An undriven line shows the inverse of the device's last bit, so a stale bit never passes
   assign sdio_in = sdio_oe ? sdio_out : (h_oe ? h_d : ~sdio_out);

   // Idle pins: clock stands low and chip select high between frames
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      h_d = 1'b0;
      h_oe = 1'b0;
      saw_sdio = 1'b0;
      saw_sdo = 1'b0;
   end

   // ==========================================
   // One frame; data changes while sclk is low, samples at the rise
   task automatic xfer(input logic rd, input logic [12:0] a, input logic lsb,
         input logic osel, input int n, inout logic [15:0] v);
      logic [15:0] ins;
      int idx;
      ins = {rd, 2'b00, a};
      saw_sdio = 1'b0;
      saw_sdo = 1'b0;
      cs_n <= 1'b0;
      h_oe <= 1'b1;
      for (int i = 15; i >= 0; i--) begin
         sclk <= 1'b0;
         h_d <= ins[i];
         #HALF sclk <= 1'b1;
         #HALF;
      end
      h_oe <= ~rd;
      for (int k = 0; k < 8 * n; k++) begin
         idx = ((k < 8 && n == 2) ? 8 : 0) + (lsb ? k % 8 : 7 - k % 8);
         sclk <= 1'b0;
         h_d <= v[idx];
         #HALF sclk <= 1'b1;
         if (rd) begin
            // A released output pin shows the inverse of its last level
            v[idx] = osel ? (sdo_oe ? sdo_out : ~sdo_out) : sdio_in;
            saw_sdio = saw_sdio | sdio_oe;
            saw_sdo = saw_sdo | sdo_oe;
         end
         #HALF;
      end
      sclk <= 1'b0;
      #HALF cs_n <= 1'b1;
      h_oe <= 1'b0;
      #100;
   endtask
endmodule

// [serial_cfg_pkg.sv]
/*
 * Constants and carrier types for the serial configuration register bank:
 * register offsets, field positions, reset values, framing counts and
 * the serial engine state encoding.
 * Assumes a 13-bit register address space reached over the serial port.
 */
package serial_cfg_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [12:0] OFF_PORT_CFG = 13'h0000;
   localparam logic [12:0] OFF_READBACK = 13'h0004;
   localparam logic [12:0] OFF_NVM_STATUS = 13'h0B00;
   localparam logic [12:0] OFF_NVM_ERROR = 13'h0B01;
   localparam logic [12:0] OFF_NVM_CTRL1 = 13'h0B02;
   localparam logic [12:0] OFF_NVM_CTRL2 = 13'h0B03;

   // ==========================================================
   // Field positions
   localparam int CFG_OUT_SEL = 7;
   localparam int CFG_LSB_FIRST = 6;
   localparam int CFG_SOFT_RST = 5;
   localparam int RB_ACTIVE = 0;
   localparam int NVC1_WR_EN = 0;
   localparam int NVC1_LOAD = 1;
   localparam int NVC2_STORE = 0;
   localparam int NVS_FLAG = 0;

   // ==========================================================
   // Writable masks and reset values
   localparam logic [7:0] MASK_PORT_CFG = 8'hEF;
   localparam logic [7:0] MASK_I2C_CFG = 8'h2F;
   localparam logic [7:0] MASK_READBACK = 8'h01;
   localparam logic [7:0] MASK_NVM_CTRL1 = 8'h03;
   localparam logic [7:0] MASK_NVM_CTRL2 = 8'h01;
   localparam logic [7:0] RST_PORT_CFG = 8'h00;
   localparam logic [7:0] RST_READBACK = 8'h00;
   localparam logic [7:0] RST_NVM_CTRL1 = 8'h00;
   localparam logic [7:0] RST_NVM_CTRL2 = 8'h00;

   // ==========================================================
   // Framing counts
   localparam logic [3:0] INSTR_LAST = 4'hF;
   localparam logic [2:0] BYTE_LAST = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_INSTR = 3'b010,
      ST_DATA  = 3'b100
   } ser_state_t;

   typedef struct packed {
      logic load;
      logic store;
   } nvm_req_t;

   typedef struct packed {
      logic busy;
      logic data_error;
   } nvm_stat_t;

endpackage

// [serial_cfg_regs.sv]
/*
 * Serial-port configuration and nonvolatile-store control register bank.
 * A host shifts a 16-bit instruction (read flag, two byte-count bits,
 * 13-bit address, always MSB first) then streams data bytes.
 * Assumes sclk, cs_n, sdio_in, io_update and i2c_mode arrive from outside
 * the ref_clk domain; the nonvolatile engine runs on ref_clk.
 */
// Notes on behaviour
// - Bit7 clear: bidirectional data pin, output pin off
// - Bit7 set: reads only on separate output pin
// - Bit6 clear: MSB first, address decrements
// - Bit6 set: LSB first, address increments
// - I2C operation ignores bit-order bits
// - Soft-reset bit restores all register defaults
// - Soft reset clears on next serial clock
// - I2C: soft reset clears on next SCL
// - Readback bit clear returns buffer registers
// - Readback bit set returns active registers
// - Store write enable; load bit self-clears
// - Store bit starts store then self-clears
`timescale 1ns/1ps

module serial_cfg_regs (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   // Serial port pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   output logic sdo_out,
   output logic sdo_oe,
   // Mode and update pins
   input wire logic i2c_mode,
   input wire logic io_update,
   // Nonvolatile engine
   input wire serial_cfg_pkg::nvm_stat_t nvm_stat,
   output serial_cfg_pkg::nvm_req_t nvm_req,
   output logic soft_reset
);

   // ==========================================================
   // Pin synchronisers
   logic [4:0] sync1_q, sync2_q;
   logic sclk_prev_q, upd_prev_q;
   logic sclk_s, cs_n_s, sdi_s, i2c_s, upd_s;
   logic sclk_rise, sclk_fall, upd_rise;

   // Two flops per pin; only stage two feeds logic
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_q <= 5'h01;
         sync2_q <= 5'h01;
         sclk_prev_q <= 1'b0;
         upd_prev_q <= 1'b0;
      end else if (ce) begin
         sync1_q <= {sclk, sdio_in, i2c_mode, io_update, cs_n};
         sync2_q <= sync1_q;
         sclk_prev_q <= sclk_s;
         upd_prev_q <= upd_s;
      end
   end

   assign {sclk_s, sdi_s, i2c_s, upd_s, cs_n_s} = sync2_q;
   assign sclk_rise = ce & sclk_s & ~sclk_prev_q;
   assign sclk_fall = ce & ~sclk_s & sclk_prev_q;
   assign upd_rise = ce & upd_s & ~upd_prev_q;

   // ==========================================================
   // Register storage
   logic [7:0] cfg_q, rb_q, nvc1_q, nvc2_q;
   logic [7:0] act_cfg_q, act_rb_q, act_nvc1_q, act_nvc2_q;
   logic lsb_first, wr_en, sr_fire;
   logic [12:0] addr_q;
   logic [7:0] wsh_q, wsh_d;

   // Bit order is meaningless on the I2C port, so it is forced off there
   assign lsb_first = cfg_q[serial_cfg_pkg::CFG_LSB_FIRST] & ~i2c_s;
   // Soft reset fires on the serial clock edge after the write completed
   assign sr_fire = sclk_rise & cfg_q[serial_cfg_pkg::CFG_SOFT_RST] & ~wr_en;

   // Readback mux: status flags bypass both banks
   function automatic logic [7:0] rd_val(input logic [12:0] a);
      logic act;
      act = rb_q[serial_cfg_pkg::RB_ACTIVE];
      rd_val = 8'h00;
      if (a == serial_cfg_pkg::OFF_PORT_CFG) begin
         rd_val = act ? act_cfg_q : cfg_q;
      end else if (a == serial_cfg_pkg::OFF_READBACK) begin
         rd_val = act ? act_rb_q : rb_q;
      end else if (a == serial_cfg_pkg::OFF_NVM_STATUS) begin
         rd_val[serial_cfg_pkg::NVS_FLAG] = nvm_stat.busy;
      end else if (a == serial_cfg_pkg::OFF_NVM_ERROR) begin
         rd_val[serial_cfg_pkg::NVS_FLAG] = nvm_stat.data_error;
      end else if (a == serial_cfg_pkg::OFF_NVM_CTRL1) begin
         rd_val = act ? act_nvc1_q : nvc1_q;
      end else if (a == serial_cfg_pkg::OFF_NVM_CTRL2) begin
         rd_val = act ? act_nvc2_q : nvc2_q;
      end
   endfunction

   // Buffer and active banks; a host write beats any self-clear
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg_q <= serial_cfg_pkg::RST_PORT_CFG;
         rb_q <= serial_cfg_pkg::RST_READBACK;
         nvc1_q <= serial_cfg_pkg::RST_NVM_CTRL1;
         nvc2_q <= serial_cfg_pkg::RST_NVM_CTRL2;
         act_cfg_q <= serial_cfg_pkg::RST_PORT_CFG;
         act_rb_q <= serial_cfg_pkg::RST_READBACK;
         act_nvc1_q <= serial_cfg_pkg::RST_NVM_CTRL1;
         act_nvc2_q <= serial_cfg_pkg::RST_NVM_CTRL2;
      end else if (ce) begin
         if (sr_fire) begin
            cfg_q <= serial_cfg_pkg::RST_PORT_CFG;
            rb_q <= serial_cfg_pkg::RST_READBACK;
            nvc1_q <= serial_cfg_pkg::RST_NVM_CTRL1;
            nvc2_q <= serial_cfg_pkg::RST_NVM_CTRL2;
            act_cfg_q <= serial_cfg_pkg::RST_PORT_CFG;
            act_rb_q <= serial_cfg_pkg::RST_READBACK;
            act_nvc1_q <= serial_cfg_pkg::RST_NVM_CTRL1;
            act_nvc2_q <= serial_cfg_pkg::RST_NVM_CTRL2;
         end else begin
            if (upd_rise) begin
               act_cfg_q <= cfg_q;
               act_rb_q <= rb_q;
               act_nvc1_q <= nvc1_q;
               act_nvc2_q <= nvc2_q;
            end
            if (wr_en && addr_q == serial_cfg_pkg::OFF_PORT_CFG) begin
               cfg_q <= wsh_d & (i2c_s ? serial_cfg_pkg::MASK_I2C_CFG
                                       : serial_cfg_pkg::MASK_PORT_CFG);
            end
            if (wr_en && addr_q == serial_cfg_pkg::OFF_READBACK) begin
               rb_q <= wsh_d & serial_cfg_pkg::MASK_READBACK;
            end
            if (wr_en && addr_q == serial_cfg_pkg::OFF_NVM_CTRL1) begin
               nvc1_q <= wsh_d & serial_cfg_pkg::MASK_NVM_CTRL1;
            end else begin
               nvc1_q[serial_cfg_pkg::NVC1_LOAD] <= 1'b0;
            end
            if (wr_en && addr_q == serial_cfg_pkg::OFF_NVM_CTRL2) begin
               nvc2_q <= wsh_d & serial_cfg_pkg::MASK_NVM_CTRL2;
            end else begin
               nvc2_q[serial_cfg_pkg::NVC2_STORE] <= 1'b0;
            end
         end
      end
   end

   // Commands to the nonvolatile engine, one cycle per set bit
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         nvm_req <= '0;
         soft_reset <= 1'b0;
      end else if (ce) begin
         nvm_req.load <= nvc1_q[serial_cfg_pkg::NVC1_LOAD];
         // Without the write enable a store request is dropped silently
         nvm_req.store <= nvc2_q[serial_cfg_pkg::NVC2_STORE]
                          & nvc1_q[serial_cfg_pkg::NVC1_WR_EN];
         soft_reset <= sr_fire;
      end
   end

   // ==========================================================
   // Serial engine
   serial_cfg_pkg::ser_state_t state_q;
   logic [3:0] cnt_q;
   logic [14:0] instr_q;
   logic rd_q, dout_q;
   logic [7:0] rbyte_q;
   logic [12:0] addr_next, addr_step;
   logic byte_done;

   assign wsh_d = lsb_first ? {sdi_s, wsh_q[7:1]} : {wsh_q[6:0], sdi_s};
   assign byte_done = sclk_rise & (state_q == serial_cfg_pkg::ST_DATA)
                      & (cnt_q[2:0] == serial_cfg_pkg::BYTE_LAST);
   assign wr_en = byte_done & ~rd_q & ~cs_n_s;
   assign addr_next = {instr_q[11:0], sdi_s};
   assign addr_step = lsb_first ? addr_q + 13'h0001 : addr_q - 13'h0001;

   // Instruction then streaming bytes; chip select high aborts the frame
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= serial_cfg_pkg::ST_IDLE;
         cnt_q <= 4'h0;
         instr_q <= 15'h0000;
         rd_q <= 1'b0;
         addr_q <= 13'h0000;
         wsh_q <= 8'h00;
         rbyte_q <= 8'h00;
      end else if (ce) begin
         if (cs_n_s) begin
            state_q <= serial_cfg_pkg::ST_IDLE;
            cnt_q <= 4'h0;
         end else begin
            case (state_q)
               serial_cfg_pkg::ST_IDLE: begin
                  state_q <= serial_cfg_pkg::ST_INSTR;
                  cnt_q <= 4'h0;
               end
               serial_cfg_pkg::ST_INSTR: begin
                  if (sclk_rise) begin
                     instr_q <= {instr_q[13:0], sdi_s};
                     cnt_q <= cnt_q + 4'h1;
                     if (cnt_q == serial_cfg_pkg::INSTR_LAST) begin
                        state_q <= serial_cfg_pkg::ST_DATA;
                        rd_q <= instr_q[14];
                        addr_q <= addr_next;
                        rbyte_q <= rd_val(addr_next);
                     end
                  end
               end
               serial_cfg_pkg::ST_DATA: begin
                  if (sclk_rise) begin
                     wsh_q <= wsh_d;
                     cnt_q <= {1'b0, cnt_q[2:0] + 3'h1};
                     if (cnt_q[2:0] == serial_cfg_pkg::BYTE_LAST) begin
                        addr_q <= addr_step;
                        rbyte_q <= rd_val(addr_step);
                     end
                  end
               end
               default: state_q <= serial_cfg_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // Read data changes on the falling edge so the host samples it on the rise
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dout_q <= 1'b0;
      end else if (sclk_fall && state_q == serial_cfg_pkg::ST_DATA) begin
         dout_q <= lsb_first ? rbyte_q[cnt_q[2:0]]
                             : rbyte_q[3'h7 - cnt_q[2:0]];
      end
   end

   // Pin direction follows the output-select bit
   logic reading;
   assign reading = (state_q == serial_cfg_pkg::ST_DATA) & rd_q & ~cs_n_s;
   assign sdio_oe = reading & ~cfg_q[serial_cfg_pkg::CFG_OUT_SEL];
   assign sdo_oe = reading & cfg_q[serial_cfg_pkg::CFG_OUT_SEL];
   assign sdio_out = dout_q;
   assign sdo_out = dout_q;

   // ==========================================================
   // Assertions
   a_sdo_tristate: assert property (@(posedge ref_clk) disable iff (rst)
      !cfg_q[7] |-> !sdo_oe && (reading == sdio_oe))
      else $error("output pin driven in bidirectional mode");
   a_sdio_input: assert property (@(posedge ref_clk) disable iff (rst)
      cfg_q[7] |-> !sdio_oe && (reading == sdo_oe))
      else $error("data pin driven in unidirectional mode");
   a_addr_decr: assert property (@(posedge ref_clk) disable iff (rst)
      byte_done && ce && !cs_n_s && !cfg_q[6] |=> addr_q == $past(addr_q) - 13'h0001)
      else $error("address did not decrement");
   a_addr_incr: assert property (@(posedge ref_clk) disable iff (rst)
      byte_done && ce && !cs_n_s && cfg_q[6] && !i2c_s
      |=> addr_q == $past(addr_q) + 13'h0001)
      else $error("address did not increment");
   a_i2c_order: assert property (@(posedge ref_clk) disable iff (rst)
      i2c_s |-> !lsb_first)
      else $error("bit order honoured in I2C mode");
   a_soft_defaults: assert property (@(posedge ref_clk) disable iff (rst)
      sr_fire |=> cfg_q == 8'h00 && rb_q == 8'h00 && nvc1_q == 8'h00 && soft_reset)
      else $error("soft reset did not restore defaults");
   a_soft_selfclr: assert property (@(posedge ref_clk) disable iff (rst)
      cfg_q[5] && sclk_rise && !wr_en && !i2c_s |=> !cfg_q[5])
      else $error("soft reset bit stuck after serial clock");
   a_scl_selfclr: assert property (@(posedge ref_clk) disable iff (rst)
      cfg_q[5] && sclk_rise && !wr_en && i2c_s |=> !cfg_q[5])
      else $error("soft reset bit stuck after SCL");
   a_rb_bank: assert property (@(posedge ref_clk) disable iff (rst)
      rd_val(13'h0004) == (rb_q[0] ? act_rb_q : rb_q))
      else $error("readback bank mismatch");
   a_rb_active: assert property (@(posedge ref_clk) disable iff (rst)
      rb_q[0] |-> rd_val(13'h0000) == act_cfg_q)
      else $error("active bank not returned");
   a_load_pulse: assert property (@(posedge ref_clk) disable iff (rst)
      ce && nvc1_q[1] |=> nvm_req.load ##1 (!nvm_req.load || !ce || $past(wr_en)))
      else $error("load trigger not started once");
   a_store_pulse: assert property (@(posedge ref_clk) disable iff (rst)
      ce && nvc2_q[0] && !wr_en |=> !nvc2_q[0] && (nvm_req.store == $past(nvc1_q[0])))
      else $error("store trigger misbehaved");
   a_status_ro: assert property (@(posedge ref_clk) disable iff (rst)
      rd_val(13'h0B00) == {7'h00, nvm_stat.busy}
      && rd_val(13'h0B01) == {7'h00, nvm_stat.data_error})
      else $error("status register not read-only view");

endmodule

// [tb.sv]
/*
 * Self-checking bench for the serial configuration register bank.
 * Assumes host_spi_model drives the serial pins; a register model kept
 * here predicts every readback and every command pulse.
 */
`timescale 1ns/1ps

module tb;
   logic ref_clk, rst, ce, i2c_mode, io_update;
   logic sclk, cs_n, sdio_in, sdio_out, sdio_oe, sdo_out, sdo_oe, soft_reset;
   serial_cfg_pkg::nvm_stat_t nvm_stat;
   serial_cfg_pkg::nvm_req_t nvm_req;
   int n_mismatch, samples_checked, n_load, n_store, n_srst, e_load, e_store, e_srst;
   logic [7:0] buf_m [logic [12:0]];
   logic [7:0] act_m [logic [12:0]];
   logic [15:0] d;
   logic [7:0] r;

   serial_cfg_regs u_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .sclk(sclk), .cs_n(cs_n),
      .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo_out(sdo_out),
      .sdo_oe(sdo_oe), .i2c_mode(i2c_mode), .io_update(io_update), .nvm_stat(nvm_stat),
      .nvm_req(nvm_req), .soft_reset(soft_reset));
   host_spi_model u_host (.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
      .sdio_oe(sdio_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe));

   // ==========================================
   // Clock, pulse counters and hang guard
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      n_load += (nvm_req.load === 1'b1);
      n_store += (nvm_req.store === 1'b1);
      n_srst += (soft_reset === 1'b1);
   end
   initial begin
      repeat (90000) @(posedge ref_clk);
      n_mismatch++;
      complete_run();
   end

   // ==========================================
   // Comparison, verdict and register model
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   function automatic logic [7:0] cfg(input logic [3:0] hi);
      return {hi, hi[0], hi[1], hi[2], hi[3]};
   endfunction
   function automatic logic lsb_now();
      return buf_m[serial_cfg_pkg::OFF_PORT_CFG][6] & ~i2c_mode;
   endfunction
   // Predict one byte write; triggers are counted, self-clearing bits dropped
   task automatic upd(input logic [12:0] a, input logic [7:0] v);
      logic [7:0] o;
      if (!buf_m.exists(a)) return;
      o = buf_m[a];
      case (a)
         // Target mode clears the order and output bits; the reset bit self-clears
         serial_cfg_pkg::OFF_PORT_CFG: buf_m[a] = v & 8'hDF & (i2c_mode ?
            serial_cfg_pkg::MASK_I2C_CFG : serial_cfg_pkg::MASK_PORT_CFG);
         serial_cfg_pkg::OFF_NVM_CTRL1: buf_m[a] = v & 8'h01;
         serial_cfg_pkg::OFF_NVM_CTRL2: buf_m[a] = 8'h00;
         default: buf_m[a] = v & serial_cfg_pkg::MASK_READBACK;
      endcase
      if (a == serial_cfg_pkg::OFF_NVM_CTRL1 && v[1]) e_load++;
      if (a == serial_cfg_pkg::OFF_NVM_CTRL2 && v[0] && o === 8'h00 &&
          buf_m[serial_cfg_pkg::OFF_NVM_CTRL1][0]) e_store++;
      if (a == serial_cfg_pkg::OFF_PORT_CFG && v[5]) begin
         e_srst++;
         foreach (buf_m[k]) buf_m[k] = 8'h00;
         foreach (act_m[k]) act_m[k] = 8'h00;
      end
   endtask
   task automatic wr(input logic [12:0] a, input int n, input logic [15:0] v);
      logic l;
      l = lsb_now();
      d = v;
      u_host.xfer(1'b0, a, l, 1'b0, n, d);
      upd(a, n == 2 ? v[15:8] : v[7:0]);
      if (n == 2) upd(l ? a + 13'h0001 : a - 13'h0001, v[7:0]);
   endtask
   // Read one byte and compare with the model, including which pin drove it
   task automatic rd(input logic [12:0] a);
      logic [7:0] e;
      logic os;
      os = buf_m[serial_cfg_pkg::OFF_PORT_CFG][7];
      if (a == serial_cfg_pkg::OFF_NVM_STATUS) e = {7'h00, nvm_stat.busy};
      else if (a == serial_cfg_pkg::OFF_NVM_ERROR) e = {7'h00, nvm_stat.data_error};
      else if (!buf_m.exists(a)) e = 8'h00;
      else e = buf_m[serial_cfg_pkg::OFF_READBACK][0] ? act_m[a] : buf_m[a];
      d = 16'h0000;
      u_host.xfer(1'b1, a, lsb_now(), os, 1, d);
      check(d[7:0], e);
      check({7'h00, u_host.saw_sdio}, {7'h00, ~os});
      check({7'h00, u_host.saw_sdo}, {7'h00, os});
   endtask

   // ==========================================
   // Main sequence
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      i2c_mode = 1'b0;
      io_update = 1'b0;
      nvm_stat = '0;
      {n_mismatch, samples_checked, n_load, n_store, n_srst, e_load, e_store, e_srst} = '0;
      void'($urandom(32'hC9EDBE3B));
      // Mapped places of the bank: 0x000, 0x004, 0xB02 and 0xB03
      for (int i = 0; i < 4; i++) begin
         buf_m[i == 0 ? 13'h0000 : i == 1 ? 13'h0004 : 13'h0B00 + 13'(i)] = 8'h00;
         act_m[i == 0 ? 13'h0000 : i == 1 ? 13'h0004 : 13'h0B00 + 13'(i)] = 8'h00;
      end
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      // Reset values, unmapped place included
      foreach (buf_m[k]) rd(k);
      rd(13'h0010);
      // Status flags follow the engine and ignore writes
      repeat (3) begin
         @(posedge ref_clk) nvm_stat <= 2'($urandom);
         wr(serial_cfg_pkg::OFF_NVM_STATUS, 2, 16'hFFFF);
         rd(serial_cfg_pkg::OFF_NVM_STATUS);
         rd(serial_cfg_pkg::OFF_NVM_ERROR);
      end
      // Buffer versus active readback around an update strobe
      r = 8'($urandom);
      wr(serial_cfg_pkg::OFF_NVM_CTRL1, 1, {8'h00, r[7:2], 2'b01});
      rd(serial_cfg_pkg::OFF_NVM_CTRL1);
      wr(serial_cfg_pkg::OFF_READBACK, 1, {8'h00, r[7:1], 1'b1});
      rd(serial_cfg_pkg::OFF_NVM_CTRL1);
      // Clock enable low freezes the pin sampling, so this strobe is lost
      @(posedge ref_clk) ce <= 1'b0;
      io_update <= 1'b1;
      repeat (8) @(posedge ref_clk);
      io_update <= 1'b0;
      repeat (4) @(posedge ref_clk);
      ce <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(serial_cfg_pkg::OFF_NVM_CTRL1);
      @(posedge ref_clk) io_update <= 1'b1;
      repeat (4) @(posedge ref_clk);
      io_update <= 1'b0;
      foreach (buf_m[k]) act_m[k] = buf_m[k];
      rd(serial_cfg_pkg::OFF_NVM_CTRL1);
      wr(serial_cfg_pkg::OFF_READBACK, 1, 16'h0000);
      // Load and store triggers, with and without write enable
      wr(serial_cfg_pkg::OFF_NVM_CTRL1, 1, 16'h0003);
      wr(serial_cfg_pkg::OFF_NVM_CTRL2, 1, 16'h0001);
      rd(serial_cfg_pkg::OFF_NVM_CTRL1);
      rd(serial_cfg_pkg::OFF_NVM_CTRL2);
      wr(serial_cfg_pkg::OFF_NVM_CTRL1, 1, 16'h0000);
      wr(serial_cfg_pkg::OFF_NVM_CTRL2, 1, 16'h0001);
      // Two-byte write, MSB first, address steps down
      wr(serial_cfg_pkg::OFF_NVM_CTRL2, 2, 16'h0001);
      rd(serial_cfg_pkg::OFF_NVM_CTRL1);
      // LSB first: address steps up, second byte stores with enable set
      wr(serial_cfg_pkg::OFF_NVM_CTRL1, 1, 16'h0000);
      wr(serial_cfg_pkg::OFF_PORT_CFG, 1, {8'h00, cfg(4'h4)});
      rd(serial_cfg_pkg::OFF_PORT_CFG);
      wr(serial_cfg_pkg::OFF_NVM_CTRL1, 2, 16'h0101);
      rd(serial_cfg_pkg::OFF_NVM_CTRL1);
      // Separate output pin for reads
      wr(serial_cfg_pkg::OFF_PORT_CFG, 1, {8'h00, cfg(4'h8)});
      rd(serial_cfg_pkg::OFF_PORT_CFG);
      rd(serial_cfg_pkg::OFF_NVM_CTRL1);
      // Soft reset restores defaults and clears itself
      wr(serial_cfg_pkg::OFF_READBACK, 1, 16'h0001);
      wr(serial_cfg_pkg::OFF_PORT_CFG, 1, {8'h00, cfg(4'h2)});
      rd(serial_cfg_pkg::OFF_PORT_CFG);
      rd(serial_cfg_pkg::OFF_NVM_CTRL1);
      // Target mode: a set order bit is ignored, soft reset on the next clock
      wr(serial_cfg_pkg::OFF_PORT_CFG, 1, {8'h00, cfg(4'h4)});
      @(posedge ref_clk) i2c_mode <= 1'b1;
      repeat (4) @(posedge ref_clk);
      wr(serial_cfg_pkg::OFF_NVM_CTRL1, 1, 16'h0001);
      rd(serial_cfg_pkg::OFF_NVM_CTRL1);
      wr(serial_cfg_pkg::OFF_PORT_CFG, 1, {8'h00, cfg(4'hC)});
      rd(serial_cfg_pkg::OFF_PORT_CFG);
      wr(serial_cfg_pkg::OFF_PORT_CFG, 1, {8'h00, cfg(4'h2)});
      rd(serial_cfg_pkg::OFF_PORT_CFG);
      check(8'(n_load), 8'(e_load));
      check(8'(n_store), 8'(e_store));
      check(8'(n_srst), 8'(e_srst));
      complete_run();
   end
endmodule
